// File: asts_pkg.sv
package asts_pkg;
	// register byte offsets (apb, one word each)
	localparam logic [15:0] CTRL_STATUS_OFS = 16'h0000; // conv_ctrl_status_reg
	localparam logic [15:0] CONTROL_OFS     = 16'h0004; // conv_control_reg
	localparam logic [15:0] TRIG_SRC_OFS    = 16'hFEDC; // trigger_source_reg
	localparam logic [15:0] RESULT_BASE_OFS = 16'h0040; // 12 result words
	localparam int          NUM_CH          = 12;
	localparam int          RES_W           = 10;
	// conv_ctrl_status_reg fields
	localparam int FLAG_BIT     = 7;
	localparam int IRQEN_BIT    = 6;
	localparam int SCAN_HI_BIT  = 5;
	localparam int SCAN_LO_BIT  = 4;
	localparam int CHSEL_MSB    = 3;
	localparam int CHSEL_LSB    = 0;
	// conv_control_reg fields
	localparam int TRIGGER_ENABLE_BIT     = 7;
	localparam int CKS_BIT      = 6;
	localparam int GO_BIT       = 5;
	// trigger_source_reg: bit 7 low selects the timer match
	localparam int TSRC_BIT     = 7;
	localparam logic [7:0] TRIG_SRC_RST = 8'hFF;
	// scan mode codes
	localparam logic [1:0] MODE_SINGLE = 2'b00;
	localparam logic [1:0] MODE_SCAN4  = 2'b01;
	localparam logic [1:0] MODE_SCAN8  = 2'b10;
	localparam logic [1:0] MODE_SCAN12 = 2'b11;
	// timing in states (one state = one core_clk cycle)
	localparam logic [4:0] SYNC_SLOW   = 5'd10; // 10..17 states, cks=0
	localparam logic [4:0] SYNC_FAST   = 5'd6;  // 6..9 states, cks=1
	localparam logic [8:0] SPL_SLOW    = 9'd80;
	localparam logic [8:0] SPL_FAST    = 9'd40;
	localparam logic [8:0] CONV_SLOW   = 9'd256;
	localparam logic [8:0] CONV_FAST   = 9'd128;
	typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_CONV} asts_state_t;
endpackage

// File: asts_result_if.sv
`timescale 1ns/1ps
interface asts_result_if;
	logic       wrEn;
	logic [3:0] wrCh;
	logic [9:0] wrData;
	logic [3:0] rdCh;
	logic [9:0] rdData;
	modport ctrl (output wrEn, output wrCh, output wrData, output rdCh,
		input rdData);
	modport mem (input wrEn, input wrCh, input wrData, input rdCh,
		output rdData);
endinterface

// File: asts_result_mem.sv
`timescale 1ns/1ps
// one result word per channel; read data registered
module asts_result_mem (
	input  wire logic   core_clk,
	input  wire logic   rst_n,
	asts_result_if.mem  res
);
	logic [9:0] memQ [12];

	// each channel keeps its value until that channel converts again
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 12; i++)
				memQ[i] <= 10'h000;
		end else if (res.wrEn) begin
			memQ[res.wrCh] <= res.wrData;
		end
	end

	// registered read port, an index past the array reads zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			res.rdData <= 10'h000;
		else if (res.rdCh < 4'd12)
			res.rdData <= memQ[res.rdCh];
		else
			res.rdData <= 10'h000;
	end
endmodule

// File: asts_sequencer.sv
`timescale 1ns/1ps
module asts_sequencer (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        port7_bit1,
	input  wire logic        timer_compare_output,
	input  wire logic        transfer_engine_ack,
	input  wire logic [9:0]  adc_result,
	output logic             port7_is_trigger,
	output logic             sampling,
	output logic [3:0]       adc_channel,
	output logic             conversion_end_irq
);
	asts_result_if res ();
	asts_result_mem uMem (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.res      (res)
	);

	logic                     flagQ, irqEnQ, trgeQ, cksQ, goQ;
	logic [1:0]               modeQ;
	logic [3:0]               chSelQ, chQ;
	logic [7:0]               tsrcQ;
	logic                     flagSeenQ, trigPrevQ, trigHitQ;
	logic [8:0]               cntQ;
	logic                     firstQ;
	asts_pkg::asts_state_t    stateQ;
	logic                     wrAcc, rdAcc, convDone, groupDone, trigIn;
	logic                     trigFall, goWr1, goWr0, flagRdSet;
	logic [3:0]               grpBase, grpLast;
	logic [4:0]               syncLen;
	logic [8:0]               convLen, splLen;
	logic [15:0]              resIdx;

	// channel count of a scan code
	function automatic logic [3:0] grp_size(input logic [1:0] m);
		case (m)
			asts_pkg::MODE_SCAN4:  grp_size = 4'd4;
			asts_pkg::MODE_SCAN8:  grp_size = 4'd8;
			asts_pkg::MODE_SCAN12: grp_size = 4'd12;
			default:               grp_size = 4'd1;
		endcase
	endfunction

	// first channel of the aligned group holding the selected channel
	function automatic logic [3:0] grp_base(input logic [1:0] m,
		input logic [3:0] c);
		case (m)
			asts_pkg::MODE_SCAN4:  grp_base = {c[3:2], 2'b00};
			asts_pkg::MODE_SCAN8:  grp_base = {c[3], 3'b000};
			asts_pkg::MODE_SCAN12: grp_base = 4'd0;
			default:               grp_base = c;
		endcase
	endfunction

	assign pready  = 1'b1; // zero wait states
	assign wrAcc   = psel && penable && pwrite;
	assign rdAcc   = psel && penable && !pwrite;
	assign grpBase = grp_base(modeQ, chSelQ);
	assign grpLast = 4'(grpBase + grp_size(modeQ) - 4'd1);
	assign syncLen = cksQ ? asts_pkg::SYNC_FAST : asts_pkg::SYNC_SLOW;
	assign splLen  = cksQ ? asts_pkg::SPL_FAST : asts_pkg::SPL_SLOW;
	assign convLen = cksQ ? asts_pkg::CONV_FAST : asts_pkg::CONV_SLOW;
	assign resIdx  = 16'(paddr - asts_pkg::RESULT_BASE_OFS) >> 2;

	// trigger source: timer match when selected, otherwise the pin
	assign port7_is_trigger = trgeQ;
	assign trigIn = tsrcQ[asts_pkg::TSRC_BIT] ? port7_bit1
		: timer_compare_output;
	assign trigFall = trgeQ && trigPrevQ && !trigIn;

	assign goWr1 = wrAcc && paddr == asts_pkg::CONTROL_OFS
		&& pwdata[asts_pkg::GO_BIT];
	assign goWr0 = wrAcc && paddr == asts_pkg::CONTROL_OFS
		&& !pwdata[asts_pkg::GO_BIT];
	assign convDone  = stateQ == asts_pkg::ST_CONV && cntQ == convLen - 9'd1;
	assign groupDone = convDone && (modeQ == asts_pkg::MODE_SINGLE
		|| chQ == grpLast);
	assign flagRdSet = rdAcc && paddr == asts_pkg::CTRL_STATUS_OFS && flagQ;

	// edge detector on the already-synchronous trigger input
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trigPrevQ <= 1'b1;
			trigHitQ  <= 1'b0;
		end else begin
			trigPrevQ <= trigIn;
			trigHitQ  <= trigFall; // go follows one state later
		end
	end

	// control register and go bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			trgeQ <= 1'b0;
			cksQ  <= 1'b0;
			goQ   <= 1'b0;
		end else begin
			if (wrAcc && paddr == asts_pkg::CONTROL_OFS) begin
				trgeQ <= pwdata[asts_pkg::TRIGGER_ENABLE_BIT];
				cksQ  <= pwdata[asts_pkg::CKS_BIT];
			end
			// hardware set beats a simultaneous software clear
			if (goWr1 || trigHitQ)
				goQ <= 1'b1;
			else if (groupDone && modeQ == asts_pkg::MODE_SINGLE)
				goQ <= 1'b0;
			else if (goWr0)
				goQ <= 1'b0; // only software stops a scan
		end
	end

	// status and trigger source registers: mode, channel select, irq enable, source
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			modeQ  <= asts_pkg::MODE_SINGLE;
			chSelQ <= 4'h0;
			irqEnQ <= 1'b0;
			tsrcQ  <= asts_pkg::TRIG_SRC_RST;
		end else if (wrAcc) begin
			if (paddr == asts_pkg::CTRL_STATUS_OFS) begin
				modeQ  <= pwdata[asts_pkg::SCAN_HI_BIT:asts_pkg::SCAN_LO_BIT];
				chSelQ <= pwdata[asts_pkg::CHSEL_MSB:asts_pkg::CHSEL_LSB];
				irqEnQ <= pwdata[asts_pkg::IRQEN_BIT];
			end
			if (paddr == asts_pkg::TRIG_SRC_OFS)
				tsrcQ <= pwdata[7:0];
		end
	end

	// end flag: set wins over any clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flagQ     <= 1'b0;
			flagSeenQ <= 1'b0;
		end else if (groupDone) begin
			flagQ     <= 1'b1;
			flagSeenQ <= 1'b0;
		end else if (transfer_engine_ack) begin
			flagQ     <= 1'b0;
			flagSeenQ <= 1'b0;
		end else if (wrAcc && paddr == asts_pkg::CTRL_STATUS_OFS
			&& !pwdata[asts_pkg::FLAG_BIT] && flagSeenQ) begin
			flagQ     <= 1'b0;
			flagSeenQ <= 1'b0;
		end else if (flagRdSet) begin
			flagSeenQ <= 1'b1; // arms the clear
		end
	end

	assign conversion_end_irq = flagQ && irqEnQ;

	// conversion sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= asts_pkg::ST_IDLE;
			cntQ   <= 9'd0;
			chQ    <= 4'h0;
			firstQ <= 1'b0;
		end else begin
			case (stateQ)
				asts_pkg::ST_IDLE: begin
					cntQ <= 9'd0;
					if (goQ) begin
						stateQ <= asts_pkg::ST_SYNC;
						chQ    <= grpBase;
						firstQ <= 1'b1;
					end
				end
				asts_pkg::ST_SYNC: begin
					// the idle step counts toward the delay, so the shortest
					// delay gives totals of 266 slow and 134 fast
					if (cntQ == 9'(syncLen) - 9'd2) begin
						stateQ <= asts_pkg::ST_CONV;
						cntQ   <= 9'd0;
					end else begin
						cntQ <= cntQ + 9'd1;
					end
				end
				asts_pkg::ST_CONV: begin
					if (!goQ) begin
						stateQ <= asts_pkg::ST_IDLE;
					end else if (convDone) begin
						cntQ   <= 9'd0;
						firstQ <= 1'b0;
						if (modeQ == asts_pkg::MODE_SINGLE)
							stateQ <= asts_pkg::ST_IDLE;
						else if (chQ == grpLast)
							chQ <= grpBase; // restart, no sync delay
						else
							chQ <= chQ + 4'd1;
					end else begin
						cntQ <= cntQ + 9'd1;
					end
				end
				default: stateQ <= asts_pkg::ST_IDLE;
			endcase
		end
	end

	// sampling window leads every conversion
	assign sampling    = stateQ == asts_pkg::ST_CONV && cntQ < splLen;
	assign adc_channel = chQ;

	assign res.wrEn   = convDone && goQ;
	assign res.wrCh   = chQ;
	assign res.wrData = adc_result;
	assign res.rdCh   = resIdx[3:0];

	// read mux; result reads use the memory's registered port, which the
	// setup cycle has already loaded with the addressed word
	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		if (paddr == asts_pkg::CTRL_STATUS_OFS)
			prdata[7:0] = {flagQ, irqEnQ, modeQ, chSelQ};
		else if (paddr == asts_pkg::CONTROL_OFS)
			prdata[7:0] = {trgeQ, cksQ, goQ, 5'h00};
		else if (paddr == asts_pkg::TRIG_SRC_OFS)
			prdata[7:0] = tsrcQ;
		else if (paddr >= asts_pkg::RESULT_BASE_OFS && resIdx < 16'd12
			&& paddr[1:0] == 2'b00)
			prdata[9:0] = res.rdData;
		else
			pslverr = psel && penable;
	end

	property p_go_after_edge;
		@(posedge core_clk) disable iff (!rst_n)
		trigFall |-> ##2 goQ;
	endproperty
	a_go_after_edge: assert property (p_go_after_edge)
		else $error("go not set after trigger edge");

	property p_go_one_state;
		@(posedge core_clk) disable iff (!rst_n)
		(trigFall && !goQ && !goWr1 && !trigHitQ) |=> !goQ ##1 goQ;
	endproperty
	a_go_one_state: assert property (p_go_one_state)
		else $error("go not set exactly one state after edge");

	property p_irq;
		@(posedge core_clk) disable iff (!rst_n)
		(groupDone && irqEnQ) |=> conversion_end_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq missing after group end");

	property p_flag_set;
		@(posedge core_clk) disable iff (!rst_n)
		groupDone |=> flagQ;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("end flag not set");

	property p_no_blind_clear;
		@(posedge core_clk) disable iff (!rst_n)
		(flagQ && !flagSeenQ && !transfer_engine_ack) |=> flagQ;
	endproperty
	a_no_blind_clear: assert property (p_no_blind_clear)
		else $error("flag cleared without prior read");

	property p_dte_clear;
		@(posedge core_clk) disable iff (!rst_n)
		(transfer_engine_ack && !groupDone) |=> !flagQ;
	endproperty
	a_dte_clear: assert property (p_dte_clear)
		else $error("transfer service did not clear flag");

	property p_scan_go_holds;
		@(posedge core_clk) disable iff (!rst_n)
		(goQ && modeQ != asts_pkg::MODE_SINGLE && !goWr0) |=> goQ;
	endproperty
	a_scan_go_holds: assert property (p_scan_go_holds)
		else $error("go cleared itself in scan");

	property p_single_go_clears;
		@(posedge core_clk) disable iff (!rst_n)
		(groupDone && modeQ == asts_pkg::MODE_SINGLE && !goWr1
			&& !trigHitQ) |=> !goQ;
	endproperty
	a_single_go_clears: assert property (p_single_go_clears)
		else $error("go not cleared in single mode");

	property p_sync_delay;
		@(posedge core_clk) disable iff (!rst_n)
		(stateQ == asts_pkg::ST_IDLE && goQ && !cksQ)
		|=> (stateQ == asts_pkg::ST_SYNC && cntQ == 9'd0)
		##8 (stateQ == asts_pkg::ST_SYNC && cntQ == 9'd8)
		##1 (stateQ == asts_pkg::ST_CONV && cntQ == 9'd0);
	endproperty
	a_sync_delay: assert property (p_sync_delay)
		else $error("sync delay wrong in slow setting");

	property p_sync_fast;
		@(posedge core_clk) disable iff (!rst_n)
		(stateQ == asts_pkg::ST_IDLE && goQ && cksQ)
		|=> (stateQ == asts_pkg::ST_SYNC && cntQ == 9'd0)
		##4 (stateQ == asts_pkg::ST_SYNC && cntQ == 9'd4)
		##1 (stateQ == asts_pkg::ST_CONV && cntQ == 9'd0);
	endproperty
	a_sync_fast: assert property (p_sync_fast)
		else $error("sync delay wrong in fast setting");

	property p_scan_wrap;
		@(posedge core_clk) disable iff (!rst_n)
		(convDone && goQ && modeQ != asts_pkg::MODE_SINGLE
			&& chQ == grpLast) |=> (stateQ == asts_pkg::ST_CONV
			&& cntQ == 9'd0 && chQ == grpBase);
	endproperty
	a_scan_wrap: assert property (p_scan_wrap)
		else $error("scan did not restart at group base");
endmodule

// File: asts_trig_src.sv
`timescale 1ns/1ps
// far side: drives low pulses on the trigger pin or the timer compare line
module asts_trig_src (
	input  wire logic       core_clk,
	input  wire logic       fire,
	input  wire logic       useTimer,
	input  wire logic [3:0] pulseLen,
	output logic            trigPin,
	output logic            timerOut
);
	logic [3:0] cnt;
	logic       lowNow;

	initial begin
		cnt = 4'h0;
		trigPin = 1'b1;
		timerOut = 1'b1;
	end
	assign lowNow = fire || (cnt > 4'h1);
	// both lines idle high; the falling edge is the start request
	always @(posedge core_clk) begin
		if (fire)
			cnt <= pulseLen;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		trigPin  <= !(lowNow && !useTimer);
		timerOut <= !(lowNow && useTimer);
	end
endmodule

// File: asts_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
	error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
	end end
module asts_sequencer_tb;
	localparam logic [15:0] CS = asts_pkg::CTRL_STATUS_OFS;
	localparam logic [15:0] CT = asts_pkg::CONTROL_OFS;
	localparam logic [15:0] TS = asts_pkg::TRIG_SRC_OFS;
	localparam logic [15:0] RB = asts_pkg::RESULT_BASE_OFS;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic        ack = 1'b0;
	logic [9:0]  adcRes = 10'h000;
	logic        fire = 1'b0;
	logic        useTmr = 1'b0;
	logic        pready, pslverr, trigPin, tmrOut, isTrig, samp, irq, err;
	logic [31:0] prdata, rd;
	logic [3:0]  chan;
	int          error_cnt = 0, cmp_count = 0, cyc = 0;
	int          t0, dSw, gBase, gSize;
	int          chanVal[12]; // analog level held on each input

	always #25 core_clk = ~core_clk;
	// cycle count doubles as the hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			close_out();
		end
	end
	// analog core model: result follows the selected input
	always @(posedge core_clk) adcRes <= 10'(chanVal[chan]);

	asts_sequencer dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.port7_bit1(trigPin), .timer_compare_output(tmrOut),
		.transfer_engine_ack(ack), .adc_result(adcRes),
		.port7_is_trigger(isTrig), .sampling(samp), .adc_channel(chan),
		.conversion_end_irq(irq));
	asts_trig_src src_u (.core_clk(core_clk), .fire(fire),
		.useTimer(useTmr), .pulseLen(4'h3), .trigPin(trigPin),
		.timerOut(tmrOut));

	task close_out;
		$display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one apb transfer; answer taken where pready is seen high
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// access lasts until pready is seen high; the bench timeout ends a hang
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task waitSamp(output int t);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (samp !== 1'b1 && n < 600);
		`CHK("start", 1'b1, samp)
		t = cyc;
	endtask
	task quiet(input int n);
		logic hit;
		hit = 1'b0;
		repeat (n) @(negedge core_clk) if (samp === 1'b1) hit = 1'b1;
		`CHK("quiet", 1'b0, hit)
	endtask
	task waitIrq(output int t);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		t = cyc;
	endtask
	task clrAck;
		@(posedge core_clk) ack <= 1'b1;
		@(posedge core_clk) ack <= 1'b0;
		@(negedge core_clk) `CHK("ack clear", 1'b0, irq)
	endtask
	// start a group, follow nc conversions, stop and check side effects
	task run(input logic [1:0] m, input logic [3:0] cs, input logic ck,
		input int nc, input logic useRead);
		int t, tp, w, k;
		logic [3:0] q[$];
		gSize = (m == 2'b00) ? 1 : 4 * m;
		gBase = (m == 2'b11) ? 0 : cs - cs % gSize;
		for (k = 0; k < nc; k++) q.push_back(4'(gBase + k % gSize));
		apb(1'b1, CS, 32'h40 | (m << 4) | cs);
		apb(1'b1, CT, (ck << 6) | 32'h20);
		@(negedge core_clk) t0 = cyc;
		for (k = 0; k < nc; k++) begin
			waitSamp(t);
			`CHK("channel", q.pop_front(), chan)
			if (k == 0) begin
				dSw = t - t0;
				`CHK("sync", 1'b1, ck ? dSw inside {[6:9]}
					: dSw inside {[10:17]})
			end else
				`CHK("period", ck ? 128 : 256, t - tp)
			tp = t;
			w = 0;
			while (samp === 1'b1 && w < 300) begin
				@(negedge core_clk);
				w++;
			end
			`CHK("sample", ck ? 40 : 80, w)
			`CHK("irq", k >= gSize, irq)
		end
		if (m == 2'b00) begin
			waitIrq(t);
			`CHK("conv", 1'b1, (t - t0) inside {[259:266]})
		end
		apb(1'b0, CT, 32'h0);
		`CHK("go", m != 2'b00, rd[5])
		apb(1'b1, CT, ck << 6);
		quiet(300);
		for (k = gBase; k < gBase + gSize; k++) begin
			apb(1'b0, RB + 16'(4 * k), 32'h0);
			`CHK("result", 10'(chanVal[k]), rd[9:0])
		end
		`CHK("flag", 1'b1, irq)
		if (useRead) begin
			apb(1'b1, CS, 32'h40);
			@(negedge core_clk);
			`CHK("blind clear", 1'b1, irq)
			apb(1'b0, CS, 32'h0);
			`CHK("flag read", 1'b1, rd[7])
			apb(1'b1, CS, 32'h40);
			@(negedge core_clk);
			`CHK("clear", 1'b0, irq)
		end else
			clrAck();
	endtask
	// low pulse from the far side; exp says whether a start must follow
	task trig(input logic tm, input logic exp);
		int t, n;
		@(posedge core_clk);
		useTmr <= tm;
		fire <= 1'b1;
		@(posedge core_clk) fire <= 1'b0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while ((tm ? tmrOut : trigPin) !== 1'b0 && n < 10);
		t0 = cyc;
		if (exp) begin
			waitSamp(t);
			`CHK("trig delay", dSw + 2, t - t0)
			waitIrq(t);
			`CHK("trig irq", 1'b1, irq)
			clrAck();
		end else
			quiet(40);
	endtask

	initial begin
		void'($urandom(32'h513f3294));
		for (int i = 0; i < 12; i++) chanVal[i] = $urandom % 1024;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, TS, 32'h0);
		`CHK("tsrc reset", asts_pkg::TRIG_SRC_RST, rd[7:0])
		apb(1'b0, 16'h0100, 32'h0);
		`CHK("unmapped", 1'b1, err)
		run(2'b00, 4'h2, 1'b0, 1, 1'b0);
		run(2'b01, 4'h5, 1'b1, 5, 1'b1);
		run(2'b10, 4'h3, 1'b1, 9, 1'b0);
		run(2'b11, 4'h7, 1'b1, 13, 1'b0);
		apb(1'b1, CS, 32'h42);
		apb(1'b1, CT, 32'hC0);
		@(negedge core_clk);
		`CHK("pin role", 1'b1, isTrig)
		trig(1'b0, 1'b1);
		apb(1'b1, TS, 32'h7F);
		trig(1'b0, 1'b0);
		trig(1'b1, 1'b1);
		close_out();
	end
endmodule
